// ==== dv/ovpc_analog_model.sv ====
// Purpose: Behavioural comparators and DACs beside the block
// Assumes: Levels given as 8-bit fractions of supply
// Notes: Offset trim and hysteresis have no effect here
`default_nettype none
module ovpc_analog_model (
	input wire logic [8:0] comparator_enable,
	input wire logic [71:0] reference_dac_code,
	input wire logic [71:0] input_level,
	output logic [8:0] compare_raw_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Switched-off comparator pulls its output low
	always_comb begin
		for (int n = 0; n < 9; n++) begin
			compare_raw_in[n] = comparator_enable[n] && (input_level[8*n+:8] > reference_dac_code[8*n+:8]);
		end
	end
endmodule
`default_nettype wire

// ==== dv/ovpc_top_bench.sv ====
// Purpose: Self-checking bench of the protection channel control block
// Assumes: One wait cycle per bus access, debounce code n needs 2^n-1 edges, one for code 0
// Notes: Calibration steps are software; t_calibration walks them by register writes on channel 3, then enables the DAC on channel 0
`default_nettype none
module ovpc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
	logic six_a, six_b, sev_a, sev_b;
	logic [5:0] avs_address = 6'h00;
	logic [3:0] avs_byteenable = 4'h1;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [8:0] raw, cen, den, s0, s1, s2, pos, irq;
	logic [71:0] code, level = 72'h0;
	logic [44:0] trim;
	logic [17:0] hys;
	logic [1:0] ext, negdac;
	int miscompares = 0, cmp_count = 0;
	always #5 ref_clk = ~ref_clk;
	ovpc_top i_ovpc_top (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .compare_raw_in(raw),
		.comparator_enable(cen), .reference_dac_enable(den), .reference_dac_code(code), .offset_trim(trim),
		.hysteresis_select(hys), .switch_s0(s0), .switch_s1(s1), .switch_s2(s2), .external_negative_pin(ext),
		.negative_dac_select(negdac), .channel_six_pin_a(six_a), .channel_six_pin_b(six_b),
		.channel_seven_pin_a(sev_a), .channel_seven_pin_b(sev_b), .protect_output_signal(pos), .irq_request(irq));
	ovpc_analog_model i_ovpc_analog_model (.comparator_enable(cen), .reference_dac_code(code),
		.input_level(level), .compare_raw_in(raw));
	task results;
		if (miscompares == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Read data taken only at the edge where wait is low
	task acc(input logic w, input logic [5:0] a, input logic [7:0] d);
		int i;
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= {24'h0, d};
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (i == 20) begin
			miscompares++;
			results();
		end
		// Answer edge: take data, then release
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask
	task rd(input logic [5:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk("readdata", q, {24'h0, e});
	endtask
	task settle(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task t_reset_values;
		for (int n = 0; n < 9; n++) begin
			rd(6'(4 * n), 8'h00);
			rd(6'(4 * n + 1), 8'h10);
			rd(6'(4 * n + 2), 8'h00);
			rd(6'(4 * n + 3), 8'h00);
		end
		rd(6'h30, 8'h00);
		chk("offset_trim", 32'(trim == {9{5'h10}}), 32'h1);
	endtask
	task t_select_masks;
		for (int n = 0; n < 9; n++) begin
			wr(6'(4 * n + 2), 8'hff);
			rd(6'(4 * n + 2), n < 2 ? 8'h8f : (n == 6 || n == 7) ? 8'h0f : 8'h0c);
		end
		chk("hysteresis", {14'h0, hys}, {14'h0, {9{2'h3}}});
		wr(6'h02, 8'h81);
		wr(6'h06, 8'h82);
		wr(6'h1a, 8'h01);
		wr(6'h1e, 8'h01);
		settle(0);
		chk("negative_select", {28'h0, ext, negdac}, 32'h6);
		chk("shared_pins", {28'h0, six_a, six_b, sev_a, sev_b}, 32'h9);
		chk("low_dac_enable", {28'h0, den[1:0], cen[1:0]}, 32'hc);
	endtask
	task t_switches;
		logic [7:0] tv [3] = '{8'h10, 8'h50, 8'h70};
		logic [2:0] ev [3] = '{3'b110, 3'b011, 3'b101};
		for (int k = 0; k < 3; k++) begin
			wr(6'h0d, tv[k]);
			settle(0);
			chk("switches", {29'h0, s0[3], s1[3], s2[3]}, {29'h0, ev[k]});
		end
	endtask
	task t_channel_flow;
		wr(6'h0b, 8'h40);
		wr(6'h24, 8'h04);
		wr(6'h08, 8'h23);
		@(posedge ref_clk);
		level[23:16] <= 8'h80;
		settle(6);
		chk("early_output", {31'h0, pos[2]}, 32'h0);
		settle(3);
		chk("output", {31'h0, pos[2]}, 32'h1);
		chk("irq", {31'h0, irq[2]}, 32'h1);
		rd(6'h08, 8'ha3);
		rd(6'h09, 8'h90);
		wr(6'h08, 8'h63);
		settle(2);
		chk("inverted_output", {31'h0, pos[2]}, 32'h0);
		wr(6'h25, 8'h04);
		settle(0);
		chk("irq_clear", {31'h0, irq[2]}, 32'h0);
		wr(6'h08, 8'h40);
		settle(2);
		chk("disabled_output", {31'h0, pos[2]}, 32'h1);
		chk("disabled_enables", {30'h0, cen[2], den[2]}, 32'h0);
		rd(6'h09, 8'h10);
	endtask
	// Software calibration steps on channel 3, DAC enable step on channel 0; trim has no analog effect in the model
	task t_calibration;
		wr(6'h0e, 8'h00);
		wr(6'h0f, 8'h20);
		wr(6'h0c, 8'h20);
		level[31:24] <= 8'h30;
		wr(6'h0d, 8'h40);
		rd(6'h0d, 8'hc0);
		wr(6'h0d, 8'h5f);
		rd(6'h0d, 8'hdf);
		wr(6'h0d, 8'h4f);
		settle(0);
		chk("cal_trim", {27'h0, trim[19:15]}, 32'h0f);
		wr(6'h02, 8'h82);
		settle(0);
		chk("cal_dac", {30'h0, den[0], negdac[0]}, 32'h3);
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset_values();
		t_select_masks();
		t_switches();
		t_channel_flow();
		t_calibration();
		results();
	end
endmodule
`default_nettype wire

// ==== dv/ovpc_top_sva.sv ====
// Purpose: Port-level checks of the protection channel control block
// Assumes: One clock, synchronous active-high reset
// Notes: Channel 2 carries the event path checks
`default_nettype none
module ovpc_top_sva (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [8:0] compare_raw_in,
	input wire logic [8:0] comparator_enable,
	input wire logic [8:0] reference_dac_enable,
	input wire logic [71:0] reference_dac_code,
	input wire logic [44:0] offset_trim,
	input wire logic [17:0] hysteresis_select,
	input wire logic [8:0] switch_s0,
	input wire logic [8:0] switch_s1,
	input wire logic [8:0] switch_s2,
	input wire logic [1:0] external_negative_pin,
	input wire logic [1:0] negative_dac_select,
	input wire logic channel_six_pin_a,
	input wire logic channel_six_pin_b,
	input wire logic channel_seven_pin_a,
	input wire logic channel_seven_pin_b,
	input wire logic [8:0] protect_output_signal,
	input wire logic [8:0] irq_request
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Three quiet cycles leave no debounced rise to latch
	sequence ch2_held_off;
		!comparator_enable[2] [*3];
	endsequence
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus wait longer than one cycle");
	AST_WAIT_IDLE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait raised with no request");
	AST_SWITCH_PAIR: assert property ((switch_s0 & switch_s1 & switch_s2) == 9'h0 &&
		((switch_s0 | switch_s1) & (switch_s1 | switch_s2) & (switch_s0 | switch_s2)) == 9'h1ff)
		else $error("switch decode not two of three");
	AST_NEG_ONE_HOT: assert property ((external_negative_pin & negative_dac_select) == 2'h0)
		else $error("both negative inputs chosen");
	AST_PIN_ONE_HOT: assert property (!(channel_six_pin_a && channel_six_pin_b) &&
		!(channel_seven_pin_a && channel_seven_pin_b))
		else $error("both shared pins chosen");
	AST_DAC_FOLLOWS_EN: assert property (reference_dac_enable[8:2] == comparator_enable[8:2])
		else $error("dac enable differs from channel enable");
	AST_IRQ_NEEDS_RAW: assert property ($rose(irq_request[2]) |-> $past(compare_raw_in[2], 2))
		else $error("event without raw high");
	AST_IRQ_DISABLED: assert property (ch2_held_off |=> !$rose(irq_request[2]))
		else $error("event on disabled channel");
	AST_IRQ_HOLD: assert property (irq_request[2] && !(avs_write && !avs_waitrequest && avs_address == 6'h25)
		|=> irq_request[2])
		else $error("pending event lost");
	AST_READ_UPPER: assert property (avs_readdata[31:9] == 23'h0)
		else $error("upper read bits set");
endmodule
bind ovpc_top ovpc_top_sva i_ovpc_top_sva (.*);
`default_nettype wire

// ==== rtl/ovpc_consts.vh ====
// Purpose: Shared constants of the over-voltage channel control block
// Assumes: Included by the debounce and top design files of the block
// Notes: Word index = {channel, register}; byte address is four times the index
// Function
// RULE1 - Nine independent channels, each fully configurable
// RULE2 - Reference is DAC level or other pin
// RULE3 - Event drives output signal, optional interrupt
// RULE4 - Control bit 7 shows debounced result
// RULE5 - Bit 6 inverts output, even when disabled
// RULE6 - Bit 5 enables; disabled forces raw low
// RULE7 - Channels 0-1 have separate DAC enable
// RULE8 - Debounce code n gives 2^(n-1)..2^n cycles
// RULE9 - Trim register bit 7 shows raw result
// RULE10 - Bit 6 selects calibration mode, resets 0
// RULE11 - Switches decoded from mode and reference
// RULE12 - Five-bit offset trim, reset value 10000
// RULE13 - Channels 0-1 negative input select decode
// RULE14 - Channels 6-7 opposite shared pin mapping
// RULE15 - Two-bit hysteresis select, reset 00
// RULE16 - Eight-bit DAC code, reset zero
// RULE17 - Software prepares hysteresis, mode, DAC code
// RULE18 - Software searches trim upward from 00000
// RULE19 - Software restarts search at 11111
// RULE20 - Software searches down, writes average
// RULE21 - Software enables DAC for channels 0-1
// RULE22 - Debounce needs stable value, change restarts
// RULE23 - Interrupt pending on debounced rise, cleared
`ifndef OVPC_CONSTS_VH
`define OVPC_CONSTS_VH

`define OVPC_NUM_CH 9
`define OVPC_CH_LIMIT 4'h9
`define OVPC_SUB_CTRL 2'h0
`define OVPC_SUB_TRIM 2'h1
`define OVPC_SUB_SEL 2'h2
`define OVPC_SUB_CODE 2'h3
`define OVPC_IDX_IRQ_EN 6'h24
`define OVPC_IDX_IRQ_PEND 6'h25

`define OVPC_CTRL_RESULT_BIT 7
`define OVPC_CTRL_POL_BIT 6
`define OVPC_CTRL_EN_BIT 5
`define OVPC_CTRL_WMASK 8'h67
`define OVPC_CTRL_RESET 8'h00

`define OVPC_TRIM_RAW_BIT 7
`define OVPC_TRIM_MODE_BIT 6
`define OVPC_TRIM_REF_BIT 5
`define OVPC_TRIM_WMASK 8'h7f
`define OVPC_TRIM_RESET 8'h10

`define OVPC_SEL_DACEN_BIT 7
`define OVPC_SEL_MASK_LOW 8'h8f
`define OVPC_SEL_MASK_SIX_SEVEN 8'h0f
`define OVPC_SEL_MASK_OTHER 8'h0c
`define OVPC_SEL_RESET 8'h00
`define OVPC_CODE_RESET 8'h00

`define OVPC_PICK_FIRST 2'h1
`define OVPC_PICK_SECOND 2'h2

`endif

// ==== rtl/ovpc_debounce.v ====
// Purpose: Digital debounce of one raw comparator result
// Assumes: Raw input synchronous to ref_clk
// Notes: Code n needs 2^n-1 stable edges, one for code 0; the last of them loads the result register
`default_nettype none
`include "ovpc_consts.vh"
module ovpc_debounce (
	input wire ref_clk,
	input wire rst,
	input wire channel_enable,
	input wire [2:0] debounce_select,
	input wire raw_compare_result,
	output wire debounced_result
);
	reg [6:0] count_reg;
	reg result_reg;
	wire [6:0] threshold;
	wire [7:0] count_plus;

	// Shift wraps to zero for code 7, so the subtraction yields 127
	assign threshold = (7'h01 << debounce_select) - 7'h01; // RULE8
	assign count_plus = {1'b0, count_reg} + 8'h01;
	assign debounced_result = result_reg;

	always @(posedge ref_clk) begin
		if (rst || !channel_enable) begin
			count_reg <= 7'h00;
			result_reg <= 1'b0;
		end else if (raw_compare_result == result_reg) begin
			count_reg <= 7'h00; // RULE22
		end else if (count_plus >= {1'b0, threshold}) begin
			result_reg <= raw_compare_result; // RULE22
			count_reg <= 7'h00;
		end else begin
			count_reg <= count_plus[6:0]; // RULE8
		end
	end
endmodule
`default_nettype wire

// ==== rtl/ovpc_switch_decode.v ====
// Purpose: Input switch decode for one channel comparator
// Assumes: Mode and reference bits straight from the trim register
// Notes: Purely combinational
`default_nettype none
module ovpc_switch_decode (
	input wire calibration_mode,
	input wire calibration_reference_select,
	output wire switch_s0,
	output wire switch_s1,
	output wire switch_s2
);
	assign switch_s0 = ~calibration_mode | calibration_reference_select; // RULE11
	assign switch_s1 = ~calibration_mode | ~calibration_reference_select; // RULE11
	assign switch_s2 = calibration_mode; // RULE11
endmodule
`default_nettype wire

// ==== rtl/ovpc_top.v ====
// Purpose: Register file and digital control of nine protection channels
// Assumes: Avalon-MM slave with word addresses, one wait cycle per access
// Notes: Analog comparators, DACs and pin sharing sit outside this block
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`default_nettype none
`include "ovpc_consts.vh"
module ovpc_top (
	input wire ref_clk,
	input wire rst,
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire [8:0] compare_raw_in,
	output wire [8:0] comparator_enable,
	output wire [8:0] reference_dac_enable,
	output wire [71:0] reference_dac_code,
	output wire [44:0] offset_trim,
	output wire [17:0] hysteresis_select,
	output wire [8:0] switch_s0,
	output wire [8:0] switch_s1,
	output wire [8:0] switch_s2,
	output wire [1:0] external_negative_pin,
	output wire [1:0] negative_dac_select,
	output wire channel_six_pin_a,
	output wire channel_six_pin_b,
	output wire channel_seven_pin_a,
	output wire channel_seven_pin_b,
	output wire [8:0] protect_output_signal,
	output wire [8:0] irq_request
);
	// Register storage, one row per channel
	reg [7:0] ctrl_reg [0:8];
	reg [7:0] trim_reg [0:8];
	reg [7:0] sel_reg [0:8];
	reg [7:0] code_reg [0:8];

	// Interrupt and output state
	reg [8:0] irq_en_reg;
	reg [8:0] irq_pend_reg;
	reg [8:0] irq_pend_next;
	reg [8:0] deb_prev_reg;
	reg [8:0] out_reg;

	// Bus handshake state
	reg ack_reg;
	reg [31:0] rdata_reg;
	reg [31:0] rdata_next;

	wire [8:0] chan_en;
	wire [8:0] raw_gated;
	wire [8:0] deb;
	wire [8:0] deb_rise;
	wire [3:0] bus_ch;
	wire [1:0] bus_sub;
	wire bus_req;
	wire ch_hit;
	wire wr_take;
	wire irq_en_hit;
	wire irq_pend_hit;
	integer k;

	// Writable bits of the selection register differ per channel group
	function [7:0] sel_mask;
		input [3:0] ch;
		begin
			if (ch < 4'h2)
				sel_mask = `OVPC_SEL_MASK_LOW;
			else if (ch == 4'h6 || ch == 4'h7)
				sel_mask = `OVPC_SEL_MASK_SIX_SEVEN;
			else
				sel_mask = `OVPC_SEL_MASK_OTHER;
		end
	endfunction

	// Two-bit select decode, shared by the low channels and channels six and seven
	function picks;
		input [1:0] code;
		input [1:0] target;
		begin
			picks = (code == target);
		end
	endfunction

	// Bus decode
	assign bus_req = avs_read | avs_write;
	assign bus_ch = avs_address[5:2];
	assign bus_sub = avs_address[1:0];
	assign ch_hit = (bus_ch < `OVPC_CH_LIMIT);
	assign irq_en_hit = (avs_address == `OVPC_IDX_IRQ_EN);
	assign irq_pend_hit = (avs_address == `OVPC_IDX_IRQ_PEND);

	// One wait cycle lets the read data settle in a flip-flop
	assign avs_waitrequest = bus_req & ~ack_reg;
	assign avs_readdata = rdata_reg;
	assign wr_take = avs_write & ack_reg;

	always @(posedge ref_clk) begin
		if (rst)
			ack_reg <= 1'b0;
		else
			ack_reg <= bus_req & ~ack_reg;
	end

	// Per channel logic
	genvar i;
	generate
		for (i = 0; i < `OVPC_NUM_CH; i = i + 1) begin : g_ch
			assign chan_en[i] = ctrl_reg[i][`OVPC_CTRL_EN_BIT]; // RULE1
			assign raw_gated[i] = compare_raw_in[i] & chan_en[i]; // RULE6
			assign comparator_enable[i] = chan_en[i]; // RULE6

			if (i < 2) begin : g_low
				assign reference_dac_enable[i] = sel_reg[i][`OVPC_SEL_DACEN_BIT]; // RULE7
			end else begin : g_high
				assign reference_dac_enable[i] = chan_en[i]; // RULE7
			end

			assign reference_dac_code[8*i +: 8] = code_reg[i]; // RULE16
			assign offset_trim[5*i +: 5] = trim_reg[i][4:0]; // RULE12
			assign hysteresis_select[2*i +: 2] = sel_reg[i][3:2]; // RULE15

			ovpc_switch_decode u_switch (
				.calibration_mode(trim_reg[i][`OVPC_TRIM_MODE_BIT]),
				.calibration_reference_select(trim_reg[i][`OVPC_TRIM_REF_BIT]),
				.switch_s0(switch_s0[i]),
				.switch_s1(switch_s1[i]),
				.switch_s2(switch_s2[i])
			);

			ovpc_debounce u_debounce (
				.ref_clk(ref_clk),
				.rst(rst),
				.channel_enable(chan_en[i]),
				.debounce_select(ctrl_reg[i][2:0]),
				.raw_compare_result(raw_gated[i]),
				.debounced_result(deb[i])
			);
		end
	endgenerate

	// Reference routing for the channels that have a choice
	assign external_negative_pin[0] = picks(sel_reg[0][1:0], `OVPC_PICK_FIRST); // RULE13
	assign external_negative_pin[1] = picks(sel_reg[1][1:0], `OVPC_PICK_FIRST); // RULE13
	assign negative_dac_select[0] = picks(sel_reg[0][1:0], `OVPC_PICK_SECOND); // RULE13
	assign negative_dac_select[1] = picks(sel_reg[1][1:0], `OVPC_PICK_SECOND); // RULE13
	assign channel_six_pin_a = picks(sel_reg[6][1:0], `OVPC_PICK_FIRST); // RULE14
	assign channel_six_pin_b = picks(sel_reg[6][1:0], `OVPC_PICK_SECOND); // RULE14
	assign channel_seven_pin_b = picks(sel_reg[7][1:0], `OVPC_PICK_FIRST); // RULE14
	assign channel_seven_pin_a = picks(sel_reg[7][1:0], `OVPC_PICK_SECOND); // RULE14

	// Output signal and interrupt
	assign deb_rise = deb & ~deb_prev_reg;
	assign protect_output_signal = out_reg;
	assign irq_request = irq_pend_reg;

	always @(posedge ref_clk) begin
		if (rst) begin
			out_reg <= 9'h000;
			deb_prev_reg <= 9'h000;
		end else begin
			// Polarity acts even while disabled, since deb is held low then
			out_reg <= deb ^ {ctrl_reg[8][6], ctrl_reg[7][6], ctrl_reg[6][6], ctrl_reg[5][6],
				ctrl_reg[4][6], ctrl_reg[3][6], ctrl_reg[2][6], ctrl_reg[1][6], ctrl_reg[0][6]}; // RULE5
			deb_prev_reg <= deb;
		end
	end

	// Write one to clear; a rise in the same cycle keeps the bit set
	always @* begin
		irq_pend_next = irq_pend_reg;
		if (wr_take && irq_pend_hit) begin
			if (avs_byteenable[0])
				irq_pend_next[7:0] = irq_pend_next[7:0] & ~avs_writedata[7:0];
			if (avs_byteenable[1])
				irq_pend_next[8] = irq_pend_next[8] & ~avs_writedata[8];
		end
		irq_pend_next = irq_pend_next | (deb_rise & irq_en_reg & chan_en); // RULE3 RULE23
	end

	always @(posedge ref_clk) begin
		if (rst)
			irq_pend_reg <= 9'h000;
		else
			irq_pend_reg <= irq_pend_next; // RULE23
	end

	// Read mux; status bits come live from the channel logic
	always @* begin
		rdata_next = 32'h00000000;
		if (ch_hit) begin
			case (bus_sub)
				`OVPC_SUB_CTRL: begin
					rdata_next[7:0] = ctrl_reg[bus_ch];
					rdata_next[`OVPC_CTRL_RESULT_BIT] = deb[bus_ch]; // RULE4
				end
				`OVPC_SUB_TRIM: begin
					rdata_next[7:0] = trim_reg[bus_ch];
					rdata_next[`OVPC_TRIM_RAW_BIT] = raw_gated[bus_ch]; // RULE9
				end
				`OVPC_SUB_SEL: begin
					rdata_next[7:0] = sel_reg[bus_ch];
				end
				`OVPC_SUB_CODE: begin
					rdata_next[7:0] = code_reg[bus_ch];
				end
				default: begin
					rdata_next = 32'h00000000;
				end
			endcase
		end else if (irq_en_hit) begin
			rdata_next[8:0] = irq_en_reg;
		end else if (irq_pend_hit) begin
			rdata_next[8:0] = irq_pend_reg;
		end
	end

	always @(posedge ref_clk) begin
		if (rst)
			rdata_reg <= 32'h00000000;
		else if (avs_read && !ack_reg)
			rdata_reg <= rdata_next;
	end

	// Register writes; status bits are never stored, unmapped writes vanish
	always @(posedge ref_clk) begin
		if (rst) begin
			for (k = 0; k < `OVPC_NUM_CH; k = k + 1) begin
				ctrl_reg[k] <= `OVPC_CTRL_RESET;
				trim_reg[k] <= `OVPC_TRIM_RESET; // RULE10 RULE12
				sel_reg[k] <= `OVPC_SEL_RESET; // RULE15
				code_reg[k] <= `OVPC_CODE_RESET; // RULE16
			end
			irq_en_reg <= 9'h000;
		end else if (wr_take) begin
			if (ch_hit && avs_byteenable[0]) begin
				case (bus_sub)
					`OVPC_SUB_CTRL: begin
						ctrl_reg[bus_ch] <= avs_writedata[7:0] & `OVPC_CTRL_WMASK; // RULE5 RULE6 RULE8
					end
					`OVPC_SUB_TRIM: begin
						trim_reg[bus_ch] <= avs_writedata[7:0] & `OVPC_TRIM_WMASK; // RULE10 RULE12
					end
					`OVPC_SUB_SEL: begin
						sel_reg[bus_ch] <= avs_writedata[7:0] & sel_mask(bus_ch); // RULE7 RULE15
					end
					`OVPC_SUB_CODE: begin
						code_reg[bus_ch] <= avs_writedata[7:0]; // RULE2 RULE16
					end
					default: begin
						code_reg[bus_ch] <= code_reg[bus_ch];
					end
				endcase
			end
			if (irq_en_hit) begin
				if (avs_byteenable[0])
					irq_en_reg[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1])
					irq_en_reg[8] <= avs_writedata[8];
			end
		end
	end
endmodule
`default_nettype wire
